/* File: core/led_status_pkg.sv */
/*
 * Shared constants, register map and carrier structs for the LED status serializer.
 * Assumes a 100 MHz system clock and an APB master with 32-bit data.
 */
package led_status_pkg;

    // =========================================================================
    // Clock and timing.
    // =========================================================================
    localparam int CLK_HZ = 100_000_000;
    localparam int DIM_HZ = 5_000;
    localparam int DIM_CYCLES = CLK_HZ / DIM_HZ;
    localparam int PULSE_ON_PCT = 20;
    localparam int PULSE_ON_CYCLES = DIM_CYCLES * PULSE_ON_PCT / 100;
    localparam int BLINK_BASE_HZ10 = 25;
    localparam int BLINK_HALF_CYCLES = CLK_HZ * 10 / BLINK_BASE_HZ10 / 2;
    localparam int STRETCH_BASE_MS = 50;
    localparam int STRETCH_CYCLES = CLK_HZ / 1000 * STRETCH_BASE_MS;
    localparam int RESET_BLINK_MS = 1000;
    localparam int RESET_BLINK_CYCLES = CLK_HZ / 1000 * RESET_BLINK_MS;
    localparam int FAIL_DETECT_US = 1000;
    localparam int FAIL_DETECT_CYCLES = CLK_HZ / 1_000_000 * FAIL_DETECT_US;
    localparam int SHIFT_HALF_CYCLES = 50;

    // =========================================================================
    // Frame and mode codes.
    // =========================================================================
    localparam int BASIC_FRAME_BITS = 48;
    localparam int BASIC_USED_BITS = 24;
    localparam int PORT_STATUS_BITS = 12;
    localparam int ENH_FRAME_BITS = 8;
    localparam logic [3:0] MODE_SERIAL = 4'h_d;
    localparam logic [3:0] MODE_OFF = 4'h_e;
    localparam logic [3:0] MODE_ON = 4'h_f;
    localparam logic [3:0] EXT_FX1000_LINK = 4'h_0;
    localparam logic [3:0] EXT_FX100_LINK = 4'h_1;
    localparam logic [3:0] EXT_FX1000_ACT = 4'h_2;
    localparam logic [3:0] EXT_FX100_ACT = 4'h_3;
    localparam logic [3:0] EXT_OFF = 4'h_4;
    localparam logic [3:0] EXT_ON = 4'h_5;
    localparam logic [3:0] EXT_FAST_FAIL = 4'h_6;

    // =========================================================================
    // Register map, byte addresses.
    // =========================================================================
    localparam logic [11:0] ADDR_MODE0 = 12'h_000;
    localparam logic [11:0] ADDR_MODE1 = 12'h_004;
    localparam logic [11:0] ADDR_GLOBAL = 12'h_008;
    localparam logic [11:0] ADDR_STATUS = 12'h_00c;
    localparam int GLB_SWAP = 0;
    localparam int GLB_ENH_LO = 1;
    localparam int GLB_ENH_HI = 7;
    localparam int GLB_DUTY_LO = 8;
    localparam int GLB_DUTY_HI = 15;
    localparam int MODE_EXT_LO = 12;
    localparam int MODE_AFTER_RESET = 11;
    localparam logic [31:0] MODE_RESET = 32'h_0000_0800;
    localparam logic [31:0] GLOBAL_RESET = 32'h_0000_8000;

    // =========================================================================
    // Carrier structs.
    // =========================================================================
    // Per-port media status, all active high.
    typedef struct packed {
        logic an_fault;
        logic rx_act;
        logic tx_act;
        logic fiber_act;
        logic activity;
        logic collision;
        logic full_duplex;
        logic fiber_link;
        logic link10;
        logic link100;
        logic link1000;
        logic link_up;
        logic fx100_link;
        logic fx100_act;
        logic base_t1000;
        logic integrity_fail;
    } port_status_type;

    // Per-port LED pin outputs, active low like the board LEDs; fast_fail is active high.
    typedef struct packed {
        logic [3:0] led_n;
        logic fast_fail;
    } port_pins_type;

endpackage : led_status_pkg

/* File: core/led_status_serializer.sv */
/*
 * LED status logic for two PHY ports: extended modes, combine, blink and
 * pulse-stretch, pulsing, blink after reset, basic and enhanced serial
 * streams, port swap and fast link failure. Registers are on APB.
 * Assumes status inputs are synchronous to clk; only the link-side
 * failure input per port is treated as asynchronous.
 */
//
// Behaviour
// - Per-pin extended enable bit makes mode field select modes sixteen and up.
// - Modes 16/17 drive low on valid fiber 1000/100 link, else high.
// - Modes 18/19 rest high, blink on fiber activity; stretch is restarted by port activity, collision or fiber_act, not fx100_act.
// - Mode 20 forces off, 21 forces on and suppresses pulsing.
// - Mode 22 routes fast link failure onto the pin.
// - Combine asserts for primary and blinks for secondary activity.
// - Blink is 50% duty; stretch holds state for the programmed period.
// - Blink rate is 2.5, 5, 10 or 20 Hz.
// - Stretch length is 50, 100, 200 or 400 ms.
// - Port 0 rate setting applies to every pin of every port.
// - Pulsing modulates asserted LEDs at 5 kHz, 20% on.
// - All LEDs blink one second after reset unless port 0 mode bit 11 cleared.
// - Port 0 LED0 mode 0xD starts basic serial on LED0 data, LED1 clock.
// - Basic frame is 48 bits on rising clock; last 24 are ignored.
// - Each port's LED0 combine and blink settings shape its serial bits.
// - Frame order: link/act through autoneg fault, port 0 then port 1.
// - Enhanced mode: LED0..3 carry data, shift clock, load, dimming pulse.
// - Data changes on falling clock; outside latches on load falling edge.
// - Dimming pulse 5 kHz with duty from bits 15:8; bits 4:1 pick functions, any of 7:1 enables.
// - Bit 0 swaps direct LED port order, serial streams unaffected.
// - Copper link failure is flagged within 1 ms typical, 3 ms worst.
// - Fast fail is the inverse of link status except 1000BASE-T uses integrity monitor.
`timescale 1ns/1ps
module led_status_serializer import led_status_pkg::*; #(
    parameter int STRETCH_TICKS = STRETCH_CYCLES,
    parameter int RESET_BLINK_TICKS = RESET_BLINK_CYCLES,
    parameter int FAIL_TICKS = FAIL_DETECT_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire led_status_pkg::port_status_type [1:0] port_status,
    input wire logic [1:0] link_fail_raw,
    output led_status_pkg::port_pins_type [1:0] port_pins
);
    import led_status_pkg::*;

    // =========================================================================
    // State.
    // =========================================================================
    typedef enum logic [1:0] {SER_IDLE, SER_LOW, SER_HIGH, SER_LOAD} ser_state_type;

    typedef struct packed {
        logic [1:0][31:0] mode;
        logic [31:0] glb;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic [31:0] blink_cnt;
        logic blink_phase;
        logic [31:0] dim_cnt;
        logic [31:0] reset_cnt;
        logic reset_blink;
        logic [1:0][3:0][31:0] stretch_cnt;
        logic [1:0][3:0] stretch_on;
        logic [1:0][2:0] fail_sync;
        logic [1:0][31:0] fail_cnt;
        logic [1:0] fail_flag;
        ser_state_type ser_state;
        logic [31:0] ser_cnt;
        logic [7:0] bit_idx;
        logic [BASIC_FRAME_BITS-1:0] basic_sr;
        logic [1:0][ENH_FRAME_BITS-1:0] enh_sr;
        port_pins_type [1:0] pins;
    } state_type;

    state_type cur;
    state_type next_cur;

    // Rate bits of port 0 only, shared by all pins.
    logic [1:0] rate_sel;
    assign rate_sel = cur.mode[0][9:8];

    // Per-pin LED level in active-high form before pin mapping.
    logic [1:0][3:0] lit;
    logic [1:0][3:0] no_pulse;
    logic [1:0][11:0] serial_bits;

    // =========================================================================
    // Per-pin mode decode, one generate over ports and pins.
    // =========================================================================
    for (genvar p = 0; p < 2; p++) begin : g_port
        // Serial frame bits per port, shaped by LED0 combine and blink.
        always_comb begin
            logic sec;
            logic b0;
            sec = port_status[p].activity;
            b0 = cur.mode[p][4] ? cur.stretch_on[p][0] : (sec & cur.blink_phase);
            serial_bits[p] = {port_status[p].an_fault, port_status[p].rx_act,
                port_status[p].tx_act, port_status[p].fiber_act, port_status[p].activity,
                port_status[p].collision, ~port_status[p].full_duplex,
                port_status[p].fiber_link, port_status[p].link10, port_status[p].link100,
                port_status[p].link1000, port_status[p].link_up};
            if (cur.mode[p][5]) begin
                serial_bits[p][3:0] = serial_bits[p][3:0] ^ {4{b0 & sec}};
            end
        end
        for (genvar n = 0; n < 4; n++) begin : g_pin
            always_comb begin
                logic [3:0] field;
                logic ext;
                logic prim;
                logic act;
                logic shaped;
                field = cur.mode[p][n*4 +: 4];
                ext = cur.mode[p][MODE_EXT_LO + n];
                prim = 1'b0;
                act = 1'b0;
                no_pulse[p][n] = 1'b0;
                if (ext) begin
                    unique case (field)
                        EXT_FX1000_LINK: prim = port_status[p].fiber_link;
                        EXT_FX100_LINK: prim = port_status[p].fx100_link;
                        EXT_FX1000_ACT: act = port_status[p].fiber_act;
                        EXT_FX100_ACT: act = port_status[p].fx100_act;
                        EXT_OFF: prim = 1'b0;
                        EXT_ON: begin
                            prim = 1'b1;
                            no_pulse[p][n] = 1'b1;
                        end
                        EXT_FAST_FAIL: prim = cur.fail_flag[p];
                        default: prim = 1'b0;
                    endcase
                end else begin
                    unique case (field)
                        4'h_0: begin
                            prim = port_status[p].link_up;
                            act = port_status[p].activity;
                        end
                        4'h_1: begin
                            prim = port_status[p].link1000;
                            act = port_status[p].activity;
                        end
                        4'h_9: act = port_status[p].collision;
                        4'h_a: act = port_status[p].activity;
                        4'h_c: prim = port_status[p].an_fault;
                        MODE_ON: prim = 1'b1;
                        default: prim = 1'b0;
                    endcase
                end
                // Blink toggles at 50%, stretch holds a programmed time.
                shaped = cur.mode[p][4] ? cur.stretch_on[p][n] : (act & cur.blink_phase);
                if (!ext && field == 4'h_9 || !ext && field == 4'h_a || ext && field[3:1] == 3'h_1) begin
                    lit[p][n] = shaped;
                end else if (cur.mode[p][5] && act) begin
                    lit[p][n] = prim & ~shaped;
                end else begin
                    lit[p][n] = prim;
                end
            end
        end
    end

    // =========================================================================
    // Next-state logic.
    // =========================================================================
    always_comb begin
        logic basic_on;
        logic enh_on;
        logic [31:0] blink_limit;
        logic [31:0] stretch_limit;
        logic pulse_gate;
        logic [1:0] src;
        logic [3:0] lvl;
        logic [ENH_FRAME_BITS-1:0] frame;
        next_cur = cur;
        frame = '0;
        src = '0;
        lvl = '0;
        basic_on = (cur.mode[0][3:0] == MODE_SERIAL) && !cur.mode[0][MODE_EXT_LO];
        enh_on = !basic_on && (cur.glb[GLB_ENH_HI:GLB_ENH_LO] != 7'h_00);
        blink_limit = 32'(BLINK_HALF_CYCLES) >> rate_sel;
        stretch_limit = 32'(STRETCH_TICKS) << rate_sel;

        // APB slave: zero-wait access, unmapped addresses answer with error.
        next_cur.ready = psel & ~penable;
        next_cur.err = 1'b0;
        if (psel && !penable) begin
            next_cur.err = !(paddr == ADDR_MODE0 || paddr == ADDR_MODE1
                || paddr == ADDR_GLOBAL || paddr == ADDR_STATUS);
            unique case (paddr)
                ADDR_MODE0: next_cur.rdata = cur.mode[0];
                ADDR_MODE1: next_cur.rdata = cur.mode[1];
                ADDR_GLOBAL: next_cur.rdata = cur.glb;
                ADDR_STATUS: next_cur.rdata = {28'h_000_0000, cur.reset_blink,
                    enh_on, cur.fail_flag};
                default: next_cur.rdata = 32'h_0000_0000;
            endcase
        end
        if (psel && penable && pwrite) begin
            if (paddr == ADDR_MODE0) next_cur.mode[0] = pwdata;
            if (paddr == ADDR_MODE1) next_cur.mode[1] = pwdata;
            if (paddr == ADDR_GLOBAL) next_cur.glb = pwdata;
        end

        // Blink time base; one free-running divider keeps all pins in phase.
        next_cur.blink_cnt = cur.blink_cnt + 32'h_0000_0001;
        if (cur.blink_cnt + 32'h_0000_0001 >= blink_limit) begin
            next_cur.blink_cnt = 32'h_0000_0000;
            next_cur.blink_phase = ~cur.blink_phase;
        end
        next_cur.dim_cnt = (cur.dim_cnt + 32'h_0000_0001 >= 32'(DIM_CYCLES))
            ? 32'h_0000_0000 : cur.dim_cnt + 32'h_0000_0001;

        // One second of blinking after reset release.
        if (cur.reset_blink) begin
            next_cur.reset_cnt = cur.reset_cnt + 32'h_0000_0001;
            if (cur.reset_cnt + 32'h_0000_0001 >= 32'(RESET_BLINK_TICKS) ||
                !cur.mode[0][MODE_AFTER_RESET]) begin
                next_cur.reset_blink = 1'b0;
            end
        end

        // Stretch timers restart while activity is seen, then hold the time.
        for (int p = 0; p < 2; p++) begin
            for (int n = 0; n < 4; n++) begin
                if (port_status[p].activity || port_status[p].collision ||
                    port_status[p].fiber_act) begin
                    next_cur.stretch_on[p][n] = 1'b1;
                    next_cur.stretch_cnt[p][n] = stretch_limit;
                end else if (cur.stretch_cnt[p][n] != 32'h_0000_0000) begin
                    next_cur.stretch_cnt[p][n] = cur.stretch_cnt[p][n] - 32'h_0000_0001;
                end else begin
                    next_cur.stretch_on[p][n] = 1'b0;
                end
            end
            // Failure input: three flops, a high accepted when last two agree, a low at once.
            next_cur.fail_sync[p] = {cur.fail_sync[p][1:0], link_fail_raw[p]};
            if (port_status[p].fiber_link || port_status[p].fx100_link) begin
                next_cur.fail_flag[p] = 1'b0;
                next_cur.fail_cnt[p] = 32'h_0000_0000;
            end else if (!port_status[p].base_t1000) begin
                next_cur.fail_flag[p] = ~port_status[p].link_up;
            end else if (cur.fail_sync[p][2] == cur.fail_sync[p][1] && cur.fail_sync[p][2]) begin
                if (cur.fail_cnt[p] + 32'h_0000_0001 >= 32'(FAIL_TICKS)) begin
                    next_cur.fail_flag[p] = 1'b1;
                end else begin
                    next_cur.fail_cnt[p] = cur.fail_cnt[p] + 32'h_0000_0001;
                end
            end else begin
                next_cur.fail_flag[p] = port_status[p].integrity_fail;
                next_cur.fail_cnt[p] = 32'h_0000_0000;
            end
        end

        // Serial shifter: data changes on the falling clock edge.
        next_cur.ser_cnt = cur.ser_cnt + 32'h_0000_0001;
        if (!basic_on && !enh_on) begin
            next_cur.ser_state = SER_IDLE;
        end else if (cur.ser_cnt + 32'h_0000_0001 >= 32'(SHIFT_HALF_CYCLES)) begin
            next_cur.ser_cnt = 32'h_0000_0000;
            unique case (cur.ser_state)
                SER_IDLE: begin
                    next_cur.basic_sr = {24'h_00_0000, serial_bits[1], serial_bits[0]};
                    for (int p = 0; p < 2; p++) begin
                        frame = '0;
                        frame[3:0] = lit[p] & cur.glb[GLB_ENH_LO +: 4];
                        next_cur.enh_sr[p] = frame;
                    end
                    next_cur.bit_idx = 8'h_00;
                    next_cur.ser_state = SER_LOW;
                end
                SER_LOW: next_cur.ser_state = SER_HIGH;
                SER_HIGH: begin
                    next_cur.bit_idx = cur.bit_idx + 8'h_01;
                    if (cur.bit_idx + 8'h_01 >= (basic_on ? 8'(BASIC_FRAME_BITS)
                        : 8'(ENH_FRAME_BITS))) begin
                        // The last bit stays put, since the clock now rests high with no fall.
                        next_cur.ser_state = basic_on ? SER_IDLE : SER_LOAD;
                    end else begin
                        next_cur.basic_sr = cur.basic_sr >> 1;
                        for (int p = 0; p < 2; p++) begin
                            next_cur.enh_sr[p] = cur.enh_sr[p] >> 1;
                        end
                        next_cur.ser_state = SER_LOW;
                    end
                end
                SER_LOAD: next_cur.ser_state = SER_IDLE;
            endcase
        end

        // Pin assembly, active low; swap reorders only direct pins.
        pulse_gate = !cur.mode[0][6] || cur.dim_cnt < 32'(PULSE_ON_CYCLES);
        for (int p = 0; p < 2; p++) begin
            src = cur.glb[GLB_SWAP] ? 2'(1 - p) : 2'(p);
            for (int n = 0; n < 4; n++) begin
                lvl[n] = lit[src[0]][n] && (pulse_gate || no_pulse[src[0]][n]);
                if (cur.reset_blink) lvl[n] = cur.blink_phase;
            end
            if (enh_on) begin
                lvl[0] = !cur.enh_sr[p][0];
                lvl[1] = cur.ser_state == SER_LOW; // The pin is low only in the low half.
                lvl[2] = cur.ser_state != SER_LOAD;
                lvl[3] = !(cur.dim_cnt < ((32'(DIM_CYCLES) *
                    32'(cur.glb[GLB_DUTY_HI:GLB_DUTY_LO])) >> 8));
            end else if (basic_on && p == 0) begin
                lvl[0] = !cur.basic_sr[0];
                lvl[1] = cur.ser_state == SER_LOW;
            end
            next_cur.pins[p].led_n = ~lvl;
            next_cur.pins[p].fast_fail = cur.fail_flag[p];
        end
    end

    // =========================================================================
    // State register.
    // =========================================================================
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cur <= '0;
            cur.mode <= {MODE_RESET, MODE_RESET};
            cur.glb <= GLOBAL_RESET;
            cur.reset_blink <= 1'b1;
            cur.pins <= '1;
        end else begin
            cur <= next_cur;
        end
    end

    assign prdata = cur.rdata;
    assign pready = cur.ready;
    assign pslverr = cur.err;
    assign port_pins = cur.pins;

endmodule : led_status_serializer

/* File: bench/led_status_chk.sv */
/* Port checker for the LED status serializer.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps
module led_status_chk import led_status_pkg::*; #(
    parameter int RESET_BLINK_TICKS = 200,
    parameter int FAIL_TICKS = 10
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire led_status_pkg::port_status_type [1:0] port_status,
    input wire logic [1:0] link_fail_raw,
    input wire led_status_pkg::port_pins_type [1:0] port_pins
);
    localparam int FAIL_MAX = FAIL_TICKS + 8;
    localparam int AGE_MAX = RESET_BLINK_TICKS + 4;
    logic [15:0] mode0_q;
    logic [7:0] glb_q;
    int age;
    wire logic enh = |glb_q[7:1];
    wire logic sclk = port_pins[0].led_n[1];
    wire logic dout = port_pins[0].led_n[0];
    wire logic ld = port_pins[0].led_n[2];
    wire logic wr_ok = psel && penable && pready && pwrite;
    // Forced modes are judged only after the reset blink, unswapped and with serial off.
    wire logic quiet = age == AGE_MAX && !enh && !glb_q[0] && mode0_q[12];
    // ===========================================================
    // Shadow registers, so the checker knows the programmed modes.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode0_q <= MODE_RESET[15:0];
            glb_q <= GLOBAL_RESET[7:0];
            age <= 0;
        end else begin
            if (wr_ok && paddr == ADDR_MODE0) mode0_q <= pwdata[15:0];
            if (wr_ok && paddr == ADDR_GLOBAL) glb_q <= pwdata[7:0];
            if (age < AGE_MAX) age <= age + 1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // The load strobe stays low while the shift clock rests.
    sequence ld_low_s;
        (!ld && $stable(sclk))[*8];
    endsequence
    // ===========================================================
    // Assertions.
    AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("ready not one cycle after setup");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("error response malformed");
    AST_FORCE_OFF: assert property ((quiet && mode0_q[3:0] == EXT_OFF)[*3] |-> dout)
        else $error("forced off pin is lit");
    AST_FORCE_ON: assert property ((quiet && mode0_q[3:0] == EXT_ON)[*3] |-> !dout)
        else $error("forced on pin is dark or pulsed");
    AST_FAST_FAIL: assert property (port_status[0].base_t1000 && $rose(link_fail_raw[0])
        |-> ##[1:FAIL_MAX] port_pins[0].fast_fail) else $error("fast fail late");
    AST_SHIFT_HALF: assert property (enh && $past(enh, 3) && $fell(sclk) |-> ##50 $rose(sclk))
        else $error("shift clock low phase wrong");
    AST_DATA_ON_FALL: assert property (enh && $past(enh, 3) && $changed(dout) |-> $fell(sclk))
        else $error("data moved off the falling clock");
    AST_LOAD_WIDTH: assert property (enh && $past(enh, 3) && $fell(ld) |=> ld_low_s)
        else $error("load strobe too short");
endmodule : led_status_chk

bind led_status_serializer led_status_chk #(
    .RESET_BLINK_TICKS(RESET_BLINK_TICKS), .FAIL_TICKS(FAIL_TICKS)) chk (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_status(port_status), .link_fail_raw(link_fail_raw), .port_pins(port_pins));

/* File: bench/led_shift_reg_model.sv */
/* Model of the board's serial-to-parallel LED converter.
   Assumes the enhanced serial pins of one port drive it. */
`timescale 1ns/1ps
module led_shift_reg_model (
    input wire logic serial_led_shift_clk,
    input wire logic serial_led_dout,
    input wire logic serial_led_load_strobe,
    output logic [7:0] board_leds,
    output int frames
);
    logic [7:0] shreg = 8'h00;
    // ===========================================================
    // Data is taken on the rising clock, half a period after it moved.
    always @(posedge serial_led_shift_clk) begin
        shreg <= {shreg[6:0], serial_led_dout};
    end
    // Outputs change only on the falling load, so LEDs never flicker mid-shift.
    initial frames = 0;
    always @(negedge serial_led_load_strobe) begin
        board_leds <= shreg;
        frames <= frames + 1;
    end
endmodule : led_shift_reg_model

/* File: bench/tb.sv */
/* Self-checking bench for the LED status serializer.
   Assumes the APB timing and register map of the design package. */
`timescale 1ns/1ps
module tb import led_status_pkg::*;;
    localparam int BLINK_T = 200;
    localparam int FAIL_T = 10;
    logic clk, resetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    port_status_type [1:0] port_status;
    logic [1:0] link_fail_raw;
    port_pins_type [1:0] port_pins;
    logic [7:0] board_leds;
    int frames, errors, checks;
    logic [3:0] codes [9] = '{EXT_FX1000_LINK, EXT_FX1000_LINK, EXT_FX100_LINK,
        EXT_FX100_LINK, EXT_FX1000_ACT, EXT_FX100_ACT, EXT_OFF, EXT_ON, EXT_FAST_FAIL};
    logic [15:0] stats [9] = '{16'h0000, 16'h0130, 16'h0000, 16'h0158, 16'h0000,
        16'h0000, 16'h0130, 16'h0000, 16'h0000};
    logic [8:0] exps = 9'h075;
    led_status_serializer #(.STRETCH_TICKS(20), .RESET_BLINK_TICKS(BLINK_T),
        .FAIL_TICKS(FAIL_T)) uut (
        .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port_status(port_status), .link_fail_raw(link_fail_raw), .port_pins(port_pins));
    led_shift_reg_model far_end (
        .serial_led_shift_clk(port_pins[0].led_n[1]), .serial_led_dout(port_pins[0].led_n[0]),
        .serial_led_load_strobe(port_pins[0].led_n[2]), .board_leds(board_leds),
        .frames(frames));
    // ===========================================================
    // Comparison, verdict and one APB transfer that waits for ready.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : check
    task automatic end_sim();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            end_sim();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Free-running system clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Main sequence.
    initial begin
        {resetn, psel, penable, pwrite, paddr, pwdata, link_fail_raw} = '0;
        port_status = '0;
        errors = 0;
        checks = 0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        apb(1'b0, ADDR_STATUS, 32'h0000_0000);
        check(32'(rd[3]), 32'h0000_0001);
        apb(1'b0, ADDR_MODE0, 32'h0000_0000);
        check(rd, MODE_RESET);
        apb(1'b0, 12'h010, 32'h0000_0000);
        check({rd[30:0], err}, 32'h0000_0001);
        repeat (BLINK_T + 10) @(posedge clk);
        apb(1'b0, ADDR_STATUS, 32'h0000_0000);
        check(32'(rd[3]), 32'h0000_0000);
        for (int i = 0; i < 9; i++) begin
            port_status[0] <= stats[i];
            apb(1'b1, ADDR_MODE0, {16'h0000, 4'h1, 4'h8,
                ((codes[i] == EXT_ON) ? 4'h4 : 4'h0), codes[i]});
            repeat (5) @(posedge clk);
            check(32'(port_pins[0].led_n[0]), 32'(exps[i]));
        end
        apb(1'b0, ADDR_MODE0, 32'h0000_0000);
        check(rd, 32'h0000_1806);
        apb(1'b1, ADDR_GLOBAL, 32'h0000_0001);
        repeat (5) @(posedge clk);
        check(32'({port_pins[1].led_n[0], port_pins[0].led_n[0]}), 32'h0000_0001);
        port_status[0] <= 16'h0012;
        repeat (5) @(posedge clk);
        link_fail_raw[0] <= 1'b1;
        repeat (FAIL_T + 8) @(posedge clk);
        check(32'(port_pins[0].fast_fail), 32'h0000_0001);
        apb(1'b0, ADDR_STATUS, 32'h0000_0000);
        check(32'(rd[0]), 32'h0000_0001);
        apb(1'b1, ADDR_GLOBAL, 32'h0000_8002);
        // Leaving direct mode drops the load line once, so the first real frame is the second.
        for (int n = 0; n < 3000 && frames < 2; n++) @(posedge clk);
        check(32'(frames), 32'h0000_0002);
        check(32'(board_leds), 32'h0000_0080);
        apb(1'b0, ADDR_STATUS, 32'h0000_0000);
        check(32'(rd[2]), 32'h0000_0001);
        end_sim();
    end
    // Watchdog against a hang anywhere in the sequence.
    initial begin
        repeat (100000) @(posedge clk);
        errors++;
        end_sim();
    end
endmodule : tb
